// file: pkg/fbp_pkg.sv
// shared constants of the flash block protect unit
// assumes a 16-bit flash address space with the array in the upper half
package fbp_pkg;
   // ==============================================
   // register map (byte addresses on apb)
   localparam logic [11:0] CTRL_OFF    = 12'h000;
   localparam logic [11:0] PROTECT_OFF = 12'h004;
   localparam logic [11:0] TARGET_OFF  = 12'h008;
   localparam logic [11:0] STATUS_OFF  = 12'h00C;
   // ==============================================
   // control field positions
   localparam int CTRL_PGM  = 0;
   localparam int CTRL_ERS  = 1;
   localparam int CTRL_MASS = 2;
   localparam int CTRL_HV   = 3;
   // status field positions
   localparam int ST_TGT_PROT = 0;
   localparam int ST_BLOCKED  = 1;
   localparam int ST_STANDBY  = 2;
   localparam int ST_TST_HV   = 3;
   localparam int ST_ANY_PROT = 4;
   localparam int ST_START_LO = 16;
   // ==============================================
   // flash layout
   localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hFF7E;
   localparam logic [7:0]  BYTE_ERASED       = 8'hFF;
   localparam logic [7:0]  BYTE_ALL_PROT     = 8'h00;
   localparam logic [7:0]  PROTECT_RESET     = 8'hFF;
   localparam int          PAGE_BITS         = 7;
   // ==============================================
   // program/erase sequence
   typedef enum logic [2:0] {
      FBP_IDLE    = 3'b000,
      FBP_SELECT  = 3'b001,
      FBP_PROT_RD = 3'b010,
      FBP_LATCHED = 3'b011,
      FBP_HIGH_V  = 3'b100
   } fbp_seq_t;
endpackage

// file: logic/fbp_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to pclk
module fbp_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_async,
   output logic      level_q
);
   logic meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q  <= 1'b0;
         level_q <= 1'b0;
      end else begin
         meta_q  <= pin_async;
         level_q <= meta_q;
      end
   end
endmodule

// file: logic/fbp_range.sv
// protected range decode: start address from the protect byte, compare with a target
// assumes a purely combinational use inside the same clock domain
module fbp_range (
   input  wire logic [7:0]  protect_start_field,
   input  wire logic [15:0] target_addr,
   output logic [15:0]      start_addr,
   output logic             any_protected,
   output logic             target_protected
);
   // bit 15 fixed high, low seven bits zero: always a 128-byte page boundary
   assign start_addr = {1'b1, protect_start_field, {fbp_pkg::PAGE_BITS{1'b0}}};
   assign any_protected = (protect_start_field != fbp_pkg::BYTE_ERASED);
   // start runs to the array top inclusive; a zero byte gives 8000, i.e. all of it
   assign target_protected = any_protected && (target_addr >= start_addr);
endmodule

// file: logic/fbp_top.sv
// flash block protect unit: apb control of program/erase, protect byte, hv gating
// assumes cpu_wait and cpu_stop come from pclk logic; test_high_voltage is a raw pin
//
// The implementer's own choices: the register addresses and the APB register port.

// Functional notes
// - protected from start address through FFFF
// - high voltage refused for protected targets, except the protect byte or its page erase under test voltage
// - zero protect byte protects whole array
// - protect byte FF leaves array open
// - non-FF byte locks itself and block
// - mass erase disabled unless byte is FF
// - protect byte changes only with test voltage
// - protect byte lives in flash, survives reset
// - start is 1, byte, seven zeros
// - start falls on 128-byte page
// - wait aborts program/erase into standby
// - stop aborts program/erase into standby
// - wait/stop in read mode changes nothing
// - standby drives hv, program and erase controls inactive
// - high voltage needs select and sequence
// - program and erase select never both set
module fbp_top #(
   parameter logic [7:0] PROTECT_INIT = fbp_pkg::PROTECT_RESET
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        por_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cpu_wait,
   input  wire logic        cpu_stop,
   input  wire logic        test_high_voltage,
   output logic             flash_hv,
   output logic             flash_pgm,
   output logic             flash_erase,
   output logic             flash_mass,
   output logic             flash_wstrobe,
   output logic [15:0]      flash_addr,
   output logic [7:0]       flash_wdata,
   output logic             flash_standby
);
   // ==============================================
   // state
   fbp_pkg::fbp_seq_t seq_q, seq_d;
   logic        program_select_q, erase_select_q, mass_q, high_voltage_enable_q;
   logic        blocked_q, standby_q, wstrobe_q, tst_q;
   logic [15:0] target_q;
   logic [7:0]  wdata_q;
   logic [7:0]  protect_start_byte_q;
   logic [15:0] start_addr, wr_addr;
   logic        any_prot, tgt_prot, wr_acc, rd_acc, setup, wr_ctrl, wr_tgt, hv_req;
   logic        hv_ok, abort, prot_byte_tgt, erase_hits_byte, tgt_refused, pgm_write_ok;

   fbp_sync u_tst_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (test_high_voltage),
      .level_q   (tst_q)
   );

   fbp_range u_range (
      .protect_start_field (protect_start_byte_q),
      .target_addr         (target_q),
      .start_addr          (start_addr),
      .any_protected       (any_prot),
      .target_protected    (tgt_prot)
   );

   // ==============================================
   // bus decode
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign wr_ctrl = wr_acc && (paddr == fbp_pkg::CTRL_OFF);
   assign wr_tgt  = wr_acc && (paddr == fbp_pkg::TARGET_OFF);
   assign wr_addr = pwdata[15:0];
   assign hv_req  = wr_ctrl && pwdata[fbp_pkg::CTRL_HV] && !high_voltage_enable_q;
   // wait/stop only matter once a sequence is under way; plain reads are untouched
   assign abort   = (cpu_wait || cpu_stop) && (seq_q != fbp_pkg::FBP_IDLE);

   // ==============================================
   // protection decision for the latched target
   assign prot_byte_tgt = (target_q == fbp_pkg::PROTECT_BYTE_ADDR);
   assign erase_hits_byte = (target_q[15:fbp_pkg::PAGE_BITS]
                             == fbp_pkg::PROTECT_BYTE_ADDR[15:fbp_pkg::PAGE_BITS]);
   always_comb begin
      tgt_refused = tgt_prot;
      if (erase_select_q && mass_q) begin
         tgt_refused = any_prot;
      end else if ((program_select_q && prot_byte_tgt)
                   || (erase_select_q && erase_hits_byte)) begin
         // the byte itself, and its page, move only under the test voltage
         tgt_refused = !tst_q || (tgt_prot && !erase_hits_byte);
      end
   end
   assign hv_ok = (program_select_q || erase_select_q)
                  && (seq_q == fbp_pkg::FBP_LATCHED) && !tgt_refused;

   // a program write during high voltage is checked byte by byte too
   assign pgm_write_ok = wr_tgt && program_select_q && high_voltage_enable_q
                         && (seq_q == fbp_pkg::FBP_HIGH_V)
                         && !((wr_addr >= start_addr) && any_prot
                              && !(wr_addr == fbp_pkg::PROTECT_BYTE_ADDR && tst_q))
                         && !(wr_addr == fbp_pkg::PROTECT_BYTE_ADDR && !tst_q);

   // ==============================================
   // sequence
   always_comb begin
      seq_d = seq_q;
      case (seq_q)
         fbp_pkg::FBP_IDLE: begin
            if (program_select_q || erase_select_q) begin
               seq_d = fbp_pkg::FBP_SELECT;
            end
         end
         fbp_pkg::FBP_SELECT: begin
            // firmware must read the protect byte here before raising hv
            if (rd_acc && paddr == fbp_pkg::PROTECT_OFF) begin
               seq_d = fbp_pkg::FBP_PROT_RD;
            end
         end
         fbp_pkg::FBP_PROT_RD: begin
            if (wr_tgt) begin
               seq_d = fbp_pkg::FBP_LATCHED;
            end
         end
         fbp_pkg::FBP_LATCHED: begin
            if (hv_req && hv_ok) begin
               seq_d = fbp_pkg::FBP_HIGH_V;
            end
         end
         fbp_pkg::FBP_HIGH_V: begin
            if (wr_ctrl && !pwdata[fbp_pkg::CTRL_HV]) begin
               seq_d = fbp_pkg::FBP_IDLE;
            end
         end
         default: seq_d = fbp_pkg::FBP_IDLE;
      endcase
      if (seq_d != fbp_pkg::FBP_HIGH_V && !program_select_q && !erase_select_q) begin
         seq_d = fbp_pkg::FBP_IDLE;
      end
      if (abort) begin
         seq_d = fbp_pkg::FBP_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q <= fbp_pkg::FBP_IDLE;
      end else begin
         seq_q <= seq_d;
      end
   end

   // ==============================================
   // control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_select_q      <= 1'b0;
         erase_select_q        <= 1'b0;
         mass_q                <= 1'b0;
         high_voltage_enable_q <= 1'b0;
      end else if (abort) begin
         program_select_q      <= 1'b0;
         erase_select_q        <= 1'b0;
         mass_q                <= 1'b0;
         high_voltage_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         // a write asking for both selects changes neither
         if (!(pwdata[fbp_pkg::CTRL_PGM] && pwdata[fbp_pkg::CTRL_ERS])) begin
            program_select_q <= pwdata[fbp_pkg::CTRL_PGM];
            erase_select_q   <= pwdata[fbp_pkg::CTRL_ERS];
         end
         mass_q <= pwdata[fbp_pkg::CTRL_MASS];
         if (!pwdata[fbp_pkg::CTRL_HV]) begin
            high_voltage_enable_q <= 1'b0;
         end else if (hv_ok) begin
            high_voltage_enable_q <= 1'b1;
         end
      end
   end

   // blocked attempt flag; write one clears, a new block in that cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked_q <= 1'b0;
      end else if (hv_req && !hv_ok) begin
         blocked_q <= 1'b1;
      end else if (wr_acc && paddr == fbp_pkg::STATUS_OFF && pwdata[fbp_pkg::ST_BLOCKED]) begin
         blocked_q <= 1'b0;
      end
   end

   // ==============================================
   // target latch and program strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_q  <= 16'h0000;
         wdata_q   <= 8'h00;
         wstrobe_q <= 1'b0;
      end else begin
         wstrobe_q <= pgm_write_ok && !abort;
         if (wr_tgt && (seq_q == fbp_pkg::FBP_PROT_RD || pgm_write_ok)) begin
            target_q <= wr_addr;
            wdata_q  <= pwdata[23:16];
         end
      end
   end

   // ==============================================
   // protect byte: flash cell, loaded with PROTECT_INIT only by power-on (por_n), not by presetn
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         protect_start_byte_q <= PROTECT_INIT;
      end else if (pgm_write_ok && wr_addr == fbp_pkg::PROTECT_BYTE_ADDR && !abort) begin
         // programming only clears bits, as a flash cell does
         protect_start_byte_q <= protect_start_byte_q & pwdata[23:16];
      end else if (seq_q == fbp_pkg::FBP_LATCHED && hv_req && hv_ok && erase_select_q
                   && (mass_q || erase_hits_byte)) begin
         protect_start_byte_q <= fbp_pkg::BYTE_ERASED;
      end
   end

   // ==============================================
   // flash macro controls; standby forces flash_hv, flash_pgm and flash_erase low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_q <= 1'b1;
      end else if (abort) begin
         standby_q <= 1'b1;
      end else if (program_select_q || erase_select_q) begin
         standby_q <= 1'b0;
      end
   end

   assign flash_standby = standby_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_hv      <= 1'b0;
         flash_pgm     <= 1'b0;
         flash_erase   <= 1'b0;
         flash_mass    <= 1'b0;
         flash_wstrobe <= 1'b0;
         flash_addr    <= 16'h0000;
         flash_wdata   <= 8'h00;
      end else begin
         flash_hv      <= high_voltage_enable_q && !standby_q && !abort;
         flash_pgm     <= program_select_q && !standby_q && !abort;
         flash_erase   <= erase_select_q && !standby_q && !abort;
         flash_mass    <= erase_select_q && mass_q && !any_prot && !abort;
         flash_wstrobe <= wstrobe_q && !abort;
         flash_addr    <= target_q;
         flash_wdata   <= wdata_q;
      end
   end

   // ==============================================
   // apb answer: zero wait, read data prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            case (paddr)
               fbp_pkg::CTRL_OFF: begin
                  prdata[fbp_pkg::CTRL_PGM]  <= program_select_q;
                  prdata[fbp_pkg::CTRL_ERS]  <= erase_select_q;
                  prdata[fbp_pkg::CTRL_MASS] <= mass_q;
                  prdata[fbp_pkg::CTRL_HV]   <= high_voltage_enable_q;
               end
               fbp_pkg::PROTECT_OFF: prdata[7:0] <= protect_start_byte_q;
               fbp_pkg::TARGET_OFF:  prdata <= {8'h00, wdata_q, target_q};
               fbp_pkg::STATUS_OFF: begin
                  prdata[fbp_pkg::ST_TGT_PROT] <= tgt_prot;
                  prdata[fbp_pkg::ST_BLOCKED]  <= blocked_q;
                  prdata[fbp_pkg::ST_STANDBY]  <= standby_q;
                  prdata[fbp_pkg::ST_TST_HV]   <= tst_q;
                  prdata[fbp_pkg::ST_ANY_PROT] <= any_prot;
                  prdata[31:fbp_pkg::ST_START_LO] <= start_addr;
               end
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ==============================================
   // checks
   hv_needs_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(high_voltage_enable_q) |-> $past(hv_ok) && $past(seq_q) == fbp_pkg::FBP_LATCHED)
      else $error("hv rose without a permitted sequence");
   refused_hv_a: assert property (@(posedge pclk) disable iff (!presetn)
      (hv_req && !hv_ok) |=> !high_voltage_enable_q && blocked_q)
      else $error("refused hv request did not leave hv low");
   mass_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      flash_mass |-> protect_start_byte_q == fbp_pkg::BYTE_ERASED)
      else $error("mass erase with a protected block");
   select_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(program_select_q && erase_select_q))
      else $error("program and erase both selected");
   wait_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
      abort |=> flash_standby && !high_voltage_enable_q ##1 !flash_hv && !flash_pgm)
      else $error("wait or stop did not end the operation");
   read_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      ((cpu_wait || cpu_stop) && seq_q == fbp_pkg::FBP_IDLE && !program_select_q
       && !erase_select_q && !wr_ctrl) |=> $stable(standby_q))
      else $error("wait or stop disturbed read mode");
   standby_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(standby_q) && $past(standby_q, 2) |-> !flash_hv && !flash_pgm && !flash_erase)
      else $error("flash control active in standby");
   start_page_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_addr[15] && start_addr[6:0] == 7'h00 && start_addr[14:7] == protect_start_byte_q)
      else $error("start address malformed");
   byte_change_a: assert property (@(posedge pclk) disable iff (!presetn || !por_n)
      $changed(protect_start_byte_q) |-> $past(tst_q))
      else $error("protect byte changed without test voltage");
   no_prot_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wstrobe_q |-> !($past(wr_addr) >= start_addr && any_prot && !$past(tst_q)))
      else $error("program strobe into protected range");
endmodule

// file: verification/fbp_fw_model.sv
// firmware side model: apb master plus the program/erase step order
// assumes each task is entered just after a rising pclk edge
module fbp_fw_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 12'h000;
      pwdata  <= 32'h0000_0000;
   end
   // ==============================================
   // bus cycles: one idle edge after each, so no signal is driven twice in one step
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
      xfer(1'b0, a, 32'h0000_0000, r, e);
   endtask
   // ==============================================
   // select, protect read, latch target, then ask for high voltage
   task automatic prog_seq(input logic [3:0] sel, input logic [15:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      wr(fbp_pkg::STATUS_OFF, 32'h0000_0002);
      wr(fbp_pkg::CTRL_OFF, {28'h0, sel});
      rd(fbp_pkg::PROTECT_OFF, r, e);
      wr(fbp_pkg::TARGET_OFF, {8'h00, d, a});
      wr(fbp_pkg::CTRL_OFF, {28'h0, sel | 4'h8});
   endtask
endmodule

// file: verification/fbp_top_tb.sv
// self-checking bench for the flash block protect unit
// assumes the firmware model drives apb; bench drives the level inputs
module fbp_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        por_n = 1'b0;
   logic        cpu_wait = 1'b0;
   logic        cpu_stop = 1'b0;
   logic        test_high_voltage = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        flash_hv, flash_pgm, flash_erase, flash_mass, flash_wstrobe, flash_standby;
   logic [15:0] flash_addr, st_addr;
   logic [7:0]  flash_wdata, st_data;
   int          num_errors = 0;
   int          tests_run = 0;
   int          n_strobe = 0;
   always #2 pclk = ~pclk;
   fbp_top u_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_wait(cpu_wait), .cpu_stop(cpu_stop),
      .test_high_voltage(test_high_voltage), .flash_hv(flash_hv), .flash_pgm(flash_pgm),
      .flash_erase(flash_erase), .flash_mass(flash_mass), .flash_wstrobe(flash_wstrobe),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_standby(flash_standby));
   fbp_fw_model u_fw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==============================================
   // strobe monitor: counts programmed bytes seen by the flash
   always @(posedge pclk) begin
      if (flash_wstrobe === 1'b1) begin
         n_strobe++;
         st_addr = flash_addr;
         st_data = flash_wdata;
      end
   end
   // ==============================================
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      u_fw.rd(a, r, e);
      chk(what, r & m, exp);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // program one byte at the protect location; test voltage must be up
   task automatic set_protect(input logic [7:0] v);
      u_fw.prog_seq(4'h1, fbp_pkg::PROTECT_BYTE_ADDR, v);
      u_fw.wr(fbp_pkg::TARGET_OFF, {8'h00, v, fbp_pkg::PROTECT_BYTE_ADDR});
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0000_0000);
   endtask
   // target decode plus high voltage gating for one address
   task automatic t_range(input logic [15:0] a, input logic p);
      u_fw.prog_seq(4'h1, a, 8'h00);
      rdchk("target prot", fbp_pkg::STATUS_OFF, 32'h1, {31'h0, p});
      rdchk("hv gated", fbp_pkg::CTRL_OFF, 32'h8, {28'h0, ~p, 3'h0});
      if (p)
         u_fw.wr(fbp_pkg::TARGET_OFF, {8'h00, 8'h00, a});
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0000_0000);
   endtask
   // ==============================================
   // scenarios
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      chk("standby pin", {31'h0, flash_standby}, 32'h1);
      rdchk("protect", fbp_pkg::PROTECT_OFF, 32'hFF, 32'hFF);
      u_fw.wr(fbp_pkg::PROTECT_OFF, 32'h0000_0000);
      rdchk("protect ro", fbp_pkg::PROTECT_OFF, 32'hFF, 32'hFF);
      u_fw.rd(12'h010, r, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", r, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_sequence();
      int n0;
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h1);
      u_fw.wr(fbp_pkg::TARGET_OFF, 32'h0000_8000);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h9);
      rdchk("hv no read", fbp_pkg::CTRL_OFF, 32'h8, 32'h0);
      rdchk("blocked", fbp_pkg::STATUS_OFF, 32'h2, 32'h2);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h3);
      rdchk("interlock", fbp_pkg::CTRL_OFF, 32'h3, 32'h1);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      u_fw.prog_seq(4'h1, 16'h8000, 8'h00);
      rdchk("hv open", fbp_pkg::CTRL_OFF, 32'h8, 32'h8);
      repeat (2) @(posedge pclk);
      chk("hv pin", {31'h0, flash_hv}, 32'h1);
      n0 = n_strobe;
      u_fw.wr(fbp_pkg::TARGET_OFF, 32'h00A5_8010);
      repeat (3) @(posedge pclk);
      chk("strobes", n_strobe, n0 + 1);
      chk("strobe addr", {16'h0, st_addr}, 32'h8010);
      chk("strobe data", {24'h0, st_data}, 32'hA5);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      $display("test sequence done");
   endtask
   task automatic t_protect();
      int n0;
      u_fw.prog_seq(4'h1, fbp_pkg::PROTECT_BYTE_ADDR, 8'h01);
      rdchk("no test volt", fbp_pkg::CTRL_OFF, 32'h8, 32'h0);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      test_high_voltage <= 1'b1;
      repeat (4) @(posedge pclk);
      rdchk("tst seen", fbp_pkg::STATUS_OFF, 32'h8, 32'h8);
      set_protect(8'h01);
      rdchk("protect 01", fbp_pkg::PROTECT_OFF, 32'hFF, 32'h01);
      rdchk("start 8080", fbp_pkg::STATUS_OFF, 32'hFFFF_0010, 32'h8080_0010);
      n0 = n_strobe;
      t_range(16'h807F, 1'b0);
      t_range(16'h8080, 1'b1);
      set_protect(8'h00);
      rdchk("start 8000", fbp_pkg::STATUS_OFF, 32'hFFFF_0000, 32'h8000_0000);
      n0 = n_strobe;
      t_range(16'h8000, 1'b1);
      u_fw.prog_seq(4'h2, 16'hFF00, 8'h00);
      chk("erase pin", {31'h0, flash_erase}, 32'h1);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      rdchk("erased byte", fbp_pkg::PROTECT_OFF, 32'hFF, 32'hFF);
      u_fw.prog_seq(4'h6, 16'h8000, 8'h00);
      chk("mass pin", {31'h0, flash_mass}, 32'h1);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      set_protect(8'hFE);
      test_high_voltage <= 1'b0;
      repeat (4) @(posedge pclk);
      rdchk("start FF00", fbp_pkg::STATUS_OFF, 32'hFFFF_0000, 32'hFF00_0000);
      n0 = n_strobe;
      t_range(16'hFEFF, 1'b0);
      t_range(16'hFF00, 1'b1);
      t_range(16'hFFFF, 1'b1);
      u_fw.prog_seq(4'h6, 16'h8000, 8'h00);
      rdchk("mass gated", fbp_pkg::CTRL_OFF, 32'h8, 32'h0);
      chk("mass pin off", {31'h0, flash_mass}, 32'h0);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      u_fw.prog_seq(4'h1, fbp_pkg::PROTECT_BYTE_ADDR, 8'h00);
      rdchk("self lock", fbp_pkg::CTRL_OFF, 32'h8, 32'h0);
      u_fw.wr(fbp_pkg::CTRL_OFF, 32'h0);
      chk("no strobes", n_strobe, n0);
      $display("test protect done");
   endtask
   task automatic t_abort();
      for (int i = 0; i < 2; i++) begin
         u_fw.prog_seq(4'h1, 16'h8000, 8'h00);
         repeat (2) @(posedge pclk);
         cpu_wait <= (i == 0);
         cpu_stop <= (i == 1);
         @(posedge pclk);
         cpu_wait <= 1'b0;
         cpu_stop <= 1'b0;
         repeat (3) @(posedge pclk);
         chk("abort hv", {31'h0, flash_hv}, 32'h0);
         chk("abort pgm", {31'h0, flash_pgm}, 32'h0);
         chk("abort standby", {31'h0, flash_standby}, 32'h1);
         rdchk("abort ctrl", fbp_pkg::CTRL_OFF, 32'hF, 32'h0);
         rdchk("abort status", fbp_pkg::STATUS_OFF, 32'h4, 32'h4);
      end
      cpu_wait <= 1'b1;
      @(posedge pclk);
      cpu_wait <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("idle wait", {31'h0, flash_standby}, 32'h1);
      rdchk("idle protect", fbp_pkg::PROTECT_OFF, 32'hFF, 32'hFE);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("retained", fbp_pkg::PROTECT_OFF, 32'hFF, 32'hFE);
      $display("test abort done");
   endtask
   // ==============================================
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      por_n   <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_sequence();
      t_protect();
      t_abort();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      finish_test();
   end
endmodule
